/* File: opv_pkg.sv */
// Purpose: Constants for the one-time-programmable array programmer.
// Assumes: 40 MHz system clock; device clock made by an 8:1 divider (5 MHz).
// Notes: Times are held in their own unit and turned into cycle counts here.
// Notes on behaviour
// - Mode code: ten bits, LSB first, clocked
// - Serial bit changes only while clock low
// - Reset high two machine cycles first
// - Drive pulse and voltage pins high first
// - Reset held low after last bit
// - Address select high thirteen clocks, latches
// - High bits kept two clocks after fall
// - Select pulsed only for high-bit changes (the programmer pulses it in every session)
// - Twenty-five low-high pulses, then leave high
// - Device clock between 1.2 and 6 MHz
// - Mode codes 296, 292, 29A, 298 hex
`default_nettype none
package opv_pkg;
    // Clocking
    localparam int SYS_MHZ = 40;
    localparam int DEV_DIV = 8;
    localparam int DEV_HALF = DEV_DIV / 2;
    // Device clock counts
    localparam int MACH_CLKS = 12;
    localparam int RST_CLKS = 2 * MACH_CLKS;
    localparam int ADDRESS_HALF_SELECT_CLKS = 13;
    localparam int AHOLD_CLKS = 2;
    localparam int ALO_CLKS = 13;
    localparam int VERIFY_CLKS = 48;
    localparam int CODE_BITS = 10;
    localparam int PULSE_COUNT = 25;
    // Times in microseconds, then system cycles (least times rounded up)
    localparam int VPP_SETUP_US = 10;
    localparam int PULSE_LOW_US = 100;
    localparam int PULSE_HIGH_US = 10;
    localparam int VPP_HOLD_US = 10;
    localparam int VPP_SETUP_CYC = VPP_SETUP_US * SYS_MHZ;
    localparam int PULSE_LOW_CYC = PULSE_LOW_US * SYS_MHZ;
    localparam int PULSE_HIGH_CYC = PULSE_HIGH_US * SYS_MHZ;
    localparam int VPP_HOLD_CYC = VPP_HOLD_US * SYS_MHZ;
    // Mode codes
    localparam logic [9:0] CODE_USER = 10'h296;
    localparam logic [9:0] CODE_KEY = 10'h292;
    localparam logic [9:0] CODE_SEC1 = 10'h29a;
    localparam logic [9:0] CODE_SEC2 = 10'h298;
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    // Field positions
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    // Operations
    typedef enum logic [2:0] {
        OP_PROG_USER = 3'h0,
        OP_VER_USER = 3'h1,
        OP_PROG_KEY = 3'h2,
        OP_VER_KEY = 3'h3,
        OP_PROG_SEC1 = 3'h4,
        OP_PROG_SEC2 = 3'h5,
        OP_VER_SEC = 3'h6,
        OP_NONE = 3'h7
    } opv_op_e;
endpackage
`default_nettype wire

/* File: opv_programmer.sv */
// Purpose: Programmer that drives the device's program/verify pins.
// Assumes: Software sets address, data and operation over APB, then starts.
// Notes: Every session re-enters the mode with a fresh reset and mode code.
`default_nettype none
module opv_programmer
    import opv_pkg::*;
#(
    // Programming pulse low width in clock cycles
    parameter int PULSE_LOW_CLKS = PULSE_LOW_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Device clock and serial reset line
    output logic oscillator_input_o,
    output logic dev_reset_o,
    // Address port
    output logic address_half_select_o,
    output logic [7:0] addr_port_o,
    // Data port, two-way
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // Pulse and voltage pins
    output logic program_pulse_n_o,
    output logic pulse_port_pin_oe_o,
    output logic voltage_port_pin_o,
    output logic voltage_port_pin_oe_o,
    output logic vpp_high_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RST = 4'h1,
        ST_SER = 4'h2,
        ST_AHI = 4'h3,
        ST_AHOLD = 4'h4,
        ST_ALO = 4'h5,
        ST_VPP = 4'h6,
        ST_PLO = 4'h7,
        ST_PHI = 4'h8,
        ST_VOFF = 4'h9,
        ST_VER = 4'ha,
        ST_DONE = 4'hb
    } opv_state_e;

    // Turns a count into a 16-bit reload value
    function automatic logic [15:0] ld(input int n);
        ld = 16'(n - 1);
    endfunction

    // Decodes an operation into its mode code
    function automatic logic [9:0] code_of(input opv_op_e op);
        unique case (op)
            OP_PROG_USER, OP_VER_USER: code_of = CODE_USER;
            OP_PROG_KEY, OP_VER_KEY: code_of = CODE_KEY;
            OP_PROG_SEC2: code_of = CODE_SEC2;
            default: code_of = CODE_SEC1;
        endcase
    endfunction

    // Register file and bus state
    opv_op_e op;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic start;
    opv_op_e next_op;
    logic [10:0] next_addr;
    logic [7:0] next_wdata;
    logic next_done;
    logic next_start;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    // Sequencer state
    opv_state_e st;
    opv_state_e next_st;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [9:0] shreg;
    logic [9:0] next_shreg;
    logic [4:0] npulse;
    logic [4:0] next_npulse;
    logic [2:0] div;
    logic [2:0] next_div;
    logic dclk;
    logic next_dclk;
    logic fall;
    logic next_fall;
    logic [7:0] next_rdata;
    logic next_done_set;
    logic done_set;
    // Pin output state
    logic next_rst_pin;
    logic next_address_half_select;
    logic [7:0] next_aport;
    logic next_doe;
    logic next_pgm;
    logic next_vpp;
    // Data port synchroniser and operation/bus decodes
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic is_prog;
    logic is_sec;
    logic wr_acc;
    logic busy;

    assign is_prog = (op == OP_PROG_USER) || (op == OP_PROG_KEY) ||
                     (op == OP_PROG_SEC1) || (op == OP_PROG_SEC2);
    assign is_sec = (op == OP_PROG_SEC1) || (op == OP_PROG_SEC2) || (op == OP_VER_SEC);
    assign busy = (st != ST_IDLE);
    assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;

    // Bus decode and software registers
    always_comb begin
        next_op = op;
        next_addr = addr;
        next_wdata = wdata;
        next_start = 1'b0;
        next_done = done;
        next_prdata = prdata_o;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        // Answer one cycle into the access phase
        if (psel_i && penable_i && !pready_o) begin
            next_pready = 1'b1;
            next_prdata = 32'h0;
            unique case (paddr_i)
                OFS_CTRL: next_prdata = {29'h0, op};
                OFS_ADDR: next_prdata = {21'h0, addr};
                OFS_WDATA: next_prdata = {24'h0, wdata};
                OFS_STATUS: next_prdata = {30'h0, done, busy};
                OFS_RDATA: next_prdata = {24'h0, rdata};
                default: next_pslverr = 1'b1;
            endcase
        end
        // Writes take effect on the completing edge; ignored while busy
        if (wr_acc && !busy) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    next_op = opv_op_e'(pwdata_i[2:0]);
                    next_start = pwdata_i[CTRL_START_BIT];
                end
                OFS_ADDR: next_addr = pwdata_i[10:0];
                OFS_WDATA: next_wdata = pwdata_i[7:0];
                default: ;
            endcase
        end
        // Done: write one to clear; a new completion wins
        if (wr_acc && paddr_i == OFS_STATUS && pwdata_i[STAT_DONE_BIT]) begin
            next_done = 1'b0;
        end
        if (done_set) begin
            next_done = 1'b1;
        end
    end

    // Registers the bus group
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            op <= OP_NONE;
            addr <= 11'h0;
            wdata <= 8'hff;
            start <= 1'b0;
            done <= 1'b0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            op <= next_op;
            addr <= next_addr;
            wdata <= next_wdata;
            start <= next_start;
            done <= next_done;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // Sequencer: device clock, mode entry, address, pulses, verify
    always_comb begin
        next_st = st;
        next_cnt = (cnt != 16'h0) ? cnt - 16'h1 : cnt;
        next_shreg = shreg;
        next_npulse = npulse;
        next_rdata = rdata;
        next_done_set = 1'b0;
        next_rst_pin = dev_reset_o;
        next_address_half_select = address_half_select_o;
        next_aport = addr_port_o;
        next_doe = data_oe_o;
        next_pgm = program_pulse_n_o;
        next_vpp = vpp_high_o;
        next_div = (div == 3'(DEV_HALF - 1)) ? 3'h0 : div + 3'h1;
        next_dclk = (div == 3'(DEV_HALF - 1)) ? !dclk : dclk;
        next_fall = (div == 3'(DEV_HALF - 1)) && dclk;
        unique case (st)
            ST_IDLE: begin
                next_pgm = 1'b1;
                next_vpp = 1'b0;
                next_doe = 1'b0;
                if (start) begin
                    next_st = ST_RST;
                end
            end
            ST_RST: begin
                // raise reset on a clock fall, then hold it high
                if (!dev_reset_o) begin
                    if (fall) begin
                        next_rst_pin = 1'b1;
                        next_cnt = ld(RST_CLKS * DEV_DIV);
                    end
                end else if (cnt == 16'h0 && fall) begin
                    next_st = ST_SER;
                    next_shreg = code_of(op);
                    next_npulse = 5'(CODE_BITS);
                end
            end
            ST_SER: begin
                // LSB first, changed on clock fall
                if (fall) begin
                    if (npulse != 5'h0) begin
                        next_rst_pin = shreg[0];
                        next_shreg = {1'b0, shreg[9:1]};
                        next_npulse = npulse - 5'h1;
                    end else begin
                        next_rst_pin = 1'b0;
                        next_st = ST_AHI;
                        // each new session reloads the high bits
                        next_address_half_select = 1'b1;
                        next_aport = {5'h0, addr[10:8]};
                        next_cnt = ld(ADDRESS_HALF_SELECT_CLKS * DEV_DIV);
                    end
                end
            end
            ST_AHI: begin
                if (cnt == 16'h0) begin
                    next_address_half_select = 1'b0;
                    next_st = ST_AHOLD;
                    next_cnt = ld(AHOLD_CLKS * DEV_DIV);
                end
            end
            ST_AHOLD: begin
                if (cnt == 16'h0) begin
                    next_aport = addr[7:0];
                    next_st = ST_ALO;
                    next_cnt = ld(ALO_CLKS * DEV_DIV);
                end
            end
            ST_ALO: begin
                // Low byte settles, then program or verify
                if (cnt == 16'h0) begin
                    if (is_prog) begin
                        next_vpp = 1'b1;
                        next_st = ST_VPP;
                        next_npulse = 5'(PULSE_COUNT);
                        next_cnt = ld(VPP_SETUP_CYC);
                    end else begin
                        next_st = ST_VER;
                        next_cnt = ld(VERIFY_CLKS * DEV_DIV);
                    end
                end
            end
            ST_VPP: begin
                // data driven only under high voltage
                next_doe = !is_sec;
                if (cnt == 16'h0) begin
                    next_pgm = 1'b0;
                    next_st = ST_PLO;
                    next_cnt = ld(PULSE_LOW_CLKS);
                end
            end
            ST_PLO: begin
                if (cnt == 16'h0) begin
                    next_pgm = 1'b1;
                    next_npulse = npulse - 5'h1;
                    next_st = ST_PHI;
                    next_cnt = ld(PULSE_HIGH_CYC);
                end
            end
            ST_PHI: begin
                if (cnt == 16'h0) begin
                    if (npulse != 5'h0) begin
                        next_pgm = 1'b0;
                        next_st = ST_PLO;
                        next_cnt = ld(PULSE_LOW_CLKS);
                    end else begin
                        next_vpp = 1'b0;
                        // Release the data port together with the voltage
                        next_doe = 1'b0;
                        next_st = ST_VOFF;
                        next_cnt = ld(VPP_HOLD_CYC);
                    end
                end
            end
            ST_VOFF: begin
                // Release the data port before the device drives it
                next_doe = 1'b0;
                if (cnt == 16'h0) begin
                    next_st = ST_VER;
                    next_cnt = ld(VERIFY_CLKS * DEV_DIV);
                end
            end
            ST_VER: begin
                // sample after 48 clocks, pins high
                if (cnt == 16'h0) begin
                    next_rdata = din_s2;
                    next_st = ST_DONE;
                end
            end
            ST_DONE: begin
                next_done_set = 1'b1;
                next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
        endcase
    end

    // Registers the sequencer group
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st <= ST_IDLE;
            cnt <= 16'h0;
            shreg <= 10'h0;
            npulse <= 5'h0;
            div <= 3'h0;
            dclk <= 1'b0;
            fall <= 1'b0;
            rdata <= 8'h0;
            done_set <= 1'b0;
            dev_reset_o <= 1'b0;
            address_half_select_o <= 1'b0;
            addr_port_o <= 8'h0;
            data_oe_o <= 1'b0;
            program_pulse_n_o <= 1'b1;
            vpp_high_o <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            shreg <= next_shreg;
            npulse <= next_npulse;
            div <= next_div;
            dclk <= next_dclk;
            fall <= next_fall;
            rdata <= next_rdata;
            done_set <= next_done_set;
            dev_reset_o <= next_rst_pin;
            address_half_select_o <= next_address_half_select;
            addr_port_o <= next_aport;
            data_oe_o <= next_doe;
            program_pulse_n_o <= next_pgm;
            vpp_high_o <= next_vpp;
        end
    end

    // Static pin drivers and data synchroniser
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            oscillator_input_o <= 1'b0;
            data_o <= 8'hff;
            pulse_port_pin_oe_o <= 1'b0;
            voltage_port_pin_o <= 1'b1;
            voltage_port_pin_oe_o <= 1'b0;
            din_s1 <= 8'h0;
            din_s2 <= 8'h0;
        end else begin
            oscillator_input_o <= next_dclk;
            data_o <= wdata;
            // drive both pins from now on
            pulse_port_pin_oe_o <= 1'b1;
            voltage_port_pin_o <= 1'b1;
            voltage_port_pin_oe_o <= 1'b1;
            din_s1 <= data_i;
            din_s2 <= din_s1;
        end
    end
endmodule
`default_nettype wire

/* File: opv_checker.sv */
// Purpose: Assertions on the programmer's pins and APB port.
// Assumes: Package counts give the pin timing.
// Notes: Bound into every programmer instance.
`default_nettype none
module opv_checker
    import opv_pkg::*;
#(
    // Programming pulse low width in clock cycles
    parameter int PULSE_LOW_CLKS = PULSE_LOW_CYC
)
(
    // Clock, reset and APB
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    // Device pins
    input wire logic oscillator_input_o,
    input wire logic dev_reset_o,
    input wire logic address_half_select_o,
    input wire logic [7:0] addr_port_o,
    input wire logic data_oe_o,
    input wire logic program_pulse_n_o,
    input wire logic pulse_port_pin_oe_o,
    input wire logic voltage_port_pin_o,
    input wire logic voltage_port_pin_oe_o,
    input wire logic vpp_high_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Cycle counts for widths too long to unroll
    int hi_cyc = 0, fall_cyc = 0, vpp_cyc = 0, low_cyc = 0, pulses = 0;
    always_ff @(posedge clk_i) begin
        hi_cyc <= address_half_select_o ? hi_cyc + 1 : 0;
        fall_cyc <= address_half_select_o ? 0 : fall_cyc + 1;
        vpp_cyc <= vpp_high_o ? vpp_cyc + 1 : 0;
        low_cyc <= program_pulse_n_o ? 0 : low_cyc + 1;
        pulses <= !vpp_high_o ? 0 : pulses + int'($fell(program_pulse_n_o));
    end
    chk_bit_on_low: assert property (
        $changed(dev_reset_o) |-> !oscillator_input_o) else $error("mode bit moved with clock high");
    chk_pins_idle: assert property (
        $rose(resetn_i) |-> ##[1:2] (pulse_port_pin_oe_o && voltage_port_pin_oe_o && voltage_port_pin_o
        && program_pulse_n_o)) else $error("pulse or voltage pin not high after reset");
    chk_sel_width: assert property (
        $fell(address_half_select_o) |-> hi_cyc >= 104) else $error("select high too short");
    chk_high_hold: assert property (
        $changed(addr_port_o) && !address_half_select_o |-> fall_cyc >= 16) else $error("high bits held short");
    chk_port_dir: assert property (
        (address_half_select_o || !vpp_high_o) |-> !data_oe_o) else $error("data driven outside programming");
    chk_pulse_count: assert property (
        $fell(vpp_high_o) |-> pulses == 25) else $error("pulse count wrong");
    chk_pulse_width: assert property (
        $rose(program_pulse_n_o) |-> low_cyc >= PULSE_LOW_CLKS * 9 / 10 && low_cyc <= PULSE_LOW_CLKS * 11 / 10)
        else $error("pulse width wrong");
    chk_vpp_setup: assert property (
        $fell(program_pulse_n_o) |-> vpp_cyc >= 400) else $error("pulse without voltage setup");
    chk_apb_answer: assert property (
        $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o) else $error("apb answer late");
    cover property ($fell(vpp_high_o));
    cover property ($fell(address_half_select_o));
    cover property ($rose(pready_o));
endmodule
bind opv_programmer opv_checker #(.PULSE_LOW_CLKS(PULSE_LOW_CLKS)) opv_checker_i (.clk_i, .resetn_i,
    .psel_i, .penable_i, .pready_o,
    .oscillator_input_o, .dev_reset_o, .address_half_select_o, .addr_port_o, .data_oe_o, .program_pulse_n_o,
    .pulse_port_pin_oe_o, .voltage_port_pin_o, .voltage_port_pin_oe_o, .vpp_high_o);
`default_nettype wire

/* File: opv_device_model.sv */
// Purpose: Behavioural model of the device's program/verify pins.
// Assumes: Arrays start erased; the bench may preset them.
// Notes: Released data lines read high through the port pull-ups.
`default_nettype none
module opv_device_model (
    // Pins from the programmer
    input wire logic osc_i,
    input wire logic rst_i,
    input wire logic address_half_select_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] ctl_d_i,
    input wire logic ctl_oe_i,
    input wire logic pgm_n_i,
    input wire logic pgm_oe_i,
    input wire logic vpp_i,
    // Data port level
    output logic [7:0] port_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [2048];
    logic [7:0] key [16];
    logic sec1 = 1'b0, sec2 = 1'b0, pgm, mode_ok;
    logic [9:0] code = 10'h0;
    logic [2:0] a_hi = 3'h0;
    logic [7:0] lo_seen = 8'h0, q;
    logic [10:0] a;
    int hi_cnt = 0, bit_n = 0, settle = 0, pulses = 0;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (key[i]) key[i] = 8'hff;
    end
    assign pgm = pgm_oe_i ? pgm_n_i : 1'b1;
    assign mode_ok = bit_n == 10 && !rst_i;
    assign a = {a_hi, addr_i};
    always @(posedge osc_i) begin
        if (bit_n > 0 && bit_n < 10) begin
            code = {rst_i, code[9:1]};
            bit_n++;
        end else if (rst_i) begin
            hi_cnt++;
            bit_n = 0;
        end else begin
            if (hi_cnt >= 24 && bit_n == 0) begin
                code = {1'b0, code[9:1]};
                bit_n = 1;
            end
            hi_cnt = 0;
        end
    end
    // high bits latched on select fall
    always @(negedge address_half_select_i) a_hi = addr_i[2:0];
    always @(posedge osc_i) begin
        settle = (vpp_i || address_half_select_i || addr_i != lo_seen) ? 0 : settle + 1;
        lo_seen = addr_i;
    end
    always @(posedge vpp_i) pulses = 0;
    always @(posedge pgm) begin
        if (vpp_i) begin
            pulses++;
            if (pulses == 25 && mode_ok) begin
                if (code == 10'h296 && !sec1) mem[a] = port_o;
                if (code == 10'h292 && !sec1) key[a[3:0]] = port_o;
                if (code == 10'h29a) sec1 = 1'b1;
                if (code == 10'h298) sec2 = 1'b1;
            end
        end
    end
    // verify data by mode and lock bits
    always @* begin
        case (code)
            10'h296: q = sec2 ? 8'hff : ~(mem[a] ^ key[a[3:0]]);
            10'h292: q = (sec1 || sec2) ? 8'hff : key[a[3:0]];
            10'h29a: q = {sec1, sec2, 6'h3f};
            default: q = 8'hff;
        endcase
    end
    // device drives only in verify, inverted until settled
    always @* begin
        if (ctl_oe_i) port_o = ctl_d_i;
        else if (!mode_ok || vpp_i) port_o = 8'hff;
        else port_o = settle >= 48 ? q : ~q;
    end
endmodule
`default_nettype wire

/* File: opv_tb.sv */
// Purpose: Self-checking bench for the array programmer.
// Assumes: Device model on the far side, APB on the near side.
// Notes: Four programming sessions (key, user, lock one, lock two), the rest verify sessions.
`default_nettype none
module testbench
    import opv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err;
    logic [7:0] paddr_i = 8'h0, addr_port_o, data_o, data_i;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, q;
    logic pready_o, pslverr_o, oscillator_input_o, dev_reset_o, address_half_select_o, data_oe_o;
    logic program_pulse_n_o, pulse_port_pin_oe_o, voltage_port_pin_o, voltage_port_pin_oe_o, vpp_high_o;
    int n_errors = 0, total_checks = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    // Short pulses keep the run brief; the model does not time them
    opv_programmer #(.PULSE_LOW_CLKS(200)) opv_programmer_i (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .oscillator_input_o, .dev_reset_o, .address_half_select_o,
        .addr_port_o, .data_i, .data_o, .data_oe_o, .program_pulse_n_o, .pulse_port_pin_oe_o,
        .voltage_port_pin_o, .voltage_port_pin_oe_o, .vpp_high_o);
    opv_device_model opv_device_model_i (.osc_i(oscillator_input_o), .rst_i(dev_reset_o),
        .address_half_select_i(address_half_select_o), .addr_i(addr_port_o), .ctl_d_i(data_o), .ctl_oe_i(data_oe_o),
        .pgm_n_i(program_pulse_n_o), .pgm_oe_i(pulse_port_pin_oe_o), .vpp_i(vpp_high_o), .port_o(data_i));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            n_errors++;
            close_out();
        end
    end
    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // One device session: set up, start, wait done, fetch data
    task automatic run_op(input opv_op_e op, input logic [10:0] a, input logic [7:0] d);
        apb(1'b1, OFS_ADDR, {21'h0, a});
        apb(1'b1, OFS_WDATA, {24'h0, d});
        apb(1'b1, OFS_CTRL, {23'h0, 1'b1, 5'h0, op});
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[STAT_DONE_BIT] !== 1'b1);
        apb(1'b0, OFS_RDATA, 32'h0);
        q = rd;
        apb(1'b1, OFS_STATUS, 32'h2);
    endtask
    task automatic t_regs();
        apb(1'b0, OFS_WDATA, 32'h0);
        check("wdata reset", rd, 32'hff);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status idle", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask
    task automatic t_user();
        opv_device_model_i.mem[11'h7a5] = 8'h3c;
        opv_device_model_i.mem[11'h015] = 8'ha1;
        run_op(OP_VER_USER, 11'h7a5, 8'h00);
        check("user plain", q, 32'h3c);
        run_op(OP_PROG_KEY, 11'h7a5, 8'h0f);
        check("key program", q, 32'h0f);
        run_op(OP_VER_USER, 11'h7a5, 8'h00);
        check("user coded", q, {24'h0, ~(8'h3c ^ 8'h0f)});
        run_op(OP_VER_USER, 11'h015, 8'h00);
        check("user coded 2", q, {24'h0, ~(8'ha1 ^ 8'h0f)});
        run_op(OP_VER_KEY, 11'h7a5, 8'h00);
        check("key byte", q, 32'h0f);
    endtask
    task automatic t_prog();
        run_op(OP_PROG_USER, 11'h123, 8'h5a);
        check("program verify", q, 32'h5a);
        check("stored byte", {24'h0, opv_device_model_i.mem[11'h123]}, 32'h5a);
    endtask
    task automatic t_sec();
        run_op(OP_VER_SEC, 11'h000, 8'h00);
        check("lock clear", q, 32'h3f);
        run_op(OP_PROG_SEC1, 11'h000, 8'h00);
        check("lock one set", q, 32'hbf);
        run_op(OP_VER_KEY, 11'h7a5, 8'h00);
        check("key locked", q, 32'hff);
        run_op(OP_VER_USER, 11'h7a5, 8'h00);
        check("user lock1", q, 32'hcc);
        run_op(OP_VER_SEC, 11'h000, 8'h00);
        check("lock one", q, 32'hbf);
        run_op(OP_PROG_SEC2, 11'h000, 8'h00);
        check("lock two set", {31'h0, opv_device_model_i.sec2}, 32'h1);
        run_op(OP_VER_USER, 11'h7a5, 8'h00);
        check("user lock2", q, 32'hff);
        run_op(OP_VER_SEC, 11'h000, 8'h00);
        check("lock both", q, 32'hff);
    endtask
    task automatic t_rereset();
        apb(1'b1, OFS_WDATA, 32'h12);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(1'b0, OFS_WDATA, 32'h0);
        check("wdata rereset", rd, 32'hff);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_user();
        t_prog();
        t_sec();
        t_rereset();
        close_out();
    end
endmodule
`default_nettype wire
